// File: src/power_state_and_reset_manager.sv
// Purpose: power-state sequencing, carrier reset and sleep indications
// Assumes: one standby clock; inputs from pins are asynchronous
// Notes:   long counts are parameters so simulation can shorten them
`timescale 1ns/1ps
module power_state_and_reset_manager #(
	parameter int unsigned RESET_LEN = pwr_mgr_pkg::RESET_CYCLES,     // carrier reset length, cycles
	parameter int unsigned WARN_LEN  = pwr_mgr_pkg::SUSP_WARN_CYCLES  // suspend warning lead, cycles
) (
	input  wire logic clk_in,                // 125 MHz standby clock
	input  wire logic sys_rst_in,            // synchronous reset, active high
	input  wire logic power_button_n_in,     // power button pin
	input  wire logic reset_button_n_in,     // reset button pin
	input  wire logic main_power_good_in,    // main supply good, high valid
	input  wire logic main_12v_low_in,       // 12 V below minimum, high
	input  wire logic watchdog_timeout_in,   // watchdog expiry pulse, same clock
	input  wire logic sw_reset_req_in,       // software reset pulse, same clock
	input  wire logic sleep_req_in,          // software sleep request pulse
	input  wire logic power_off_req_in,      // software soft-off request pulse
	input  wire logic pcie_wake_n_in,        // pcie wake pin
	input  wire logic aux_wake_n_in,         // general wake pin
	input  wire logic battery_low_n_in,      // battery low pin
	input  wire logic overtemp_in_n_in,      // off-module over-temp pin
	input  wire logic cpu_shutdown_in,       // processor thermal shutdown, same clock
	input  wire logic mgmt_bus_alert_n_in,   // management alert pin
	input  wire logic lid_n_in,              // lid switch pin
	input  wire logic sleep_button_n_in,     // sleep button pin
	output logic      carrier_reset_out_n_out, // carrier reset, active low
	output logic      suspend_warning_n_out,   // imminent suspend, active low
	output logic      sleep_ram_state_n_out,   // suspend-to-RAM, active low
	output logic      sleep_disk_state_n_out,  // suspend-to-disk, unsupported
	output logic      soft_off_state_n_out,    // soft-off, active low
	output logic      cpu_thermal_trip_n_out,  // thermal shutdown, active low
	output logic      thermal_alarm_out,       // over-temp level
	output logic      battery_low_out,         // battery-low level
	output logic      mgmt_alert_smi_out,      // alert seen while running, pulse
	output logic      lid_event_out,           // lid change pulse
	output logic      sleep_button_event_out   // sleep button press pulse
);
	// ==================================================
	// input synchronisers
	// bit positions in the pin group, one chain each
	localparam int NSYNC       = 10;
	localparam int B_SLEEP_BTN = 9; // sleep button
	localparam int B_PWR_BTN   = 8; // power button
	localparam int B_RST_BTN   = 7; // reset button
	localparam int B_PGOOD     = 6; // main supply good
	localparam int B_PCIE_WAKE = 5; // pcie wake
	localparam int B_AUX_WAKE  = 4; // general wake
	localparam int B_BATT_LOW  = 3; // battery low
	localparam int B_OVER_TEMP = 2; // off-module over-temp
	localparam int B_ALERT     = 1; // management alert
	localparam int B_LID       = 0; // lid switch

	logic [NSYNC-1:0] raw;  // pins as they arrive
	logic [NSYNC-1:0] meta; // first stage, may be metastable
	logic [NSYNC-1:0] sync; // second stage, safe to read
	logic [NSYNC-1:0] prev; // one cycle older, for edges

	// gather the pins in bit-position order
	assign raw[B_SLEEP_BTN] = sleep_button_n_in;
	assign raw[B_PWR_BTN]   = power_button_n_in;
	assign raw[B_RST_BTN]   = reset_button_n_in;
	assign raw[B_PGOOD]     = main_power_good_in;
	assign raw[B_PCIE_WAKE] = pcie_wake_n_in;
	assign raw[B_AUX_WAKE]  = aux_wake_n_in;
	assign raw[B_BATT_LOW]  = battery_low_n_in;
	assign raw[B_OVER_TEMP] = overtemp_in_n_in;
	assign raw[B_ALERT]     = mgmt_bus_alert_n_in;
	assign raw[B_LID]       = lid_n_in;

	// first stage feeds only the second; pulled-up pins reset
	// high so no false edge follows reset
	for (genvar i = 0; i < NSYNC; i++) begin : g_sync
		always_ff @(posedge clk_in) begin
			if (sys_rst_in) begin
				meta[i] <= 1'b1;
				sync[i] <= 1'b1;
				prev[i] <= 1'b1;
			end else begin
				meta[i] <= raw[i];
				sync[i] <= meta[i];
				prev[i] <= sync[i];
			end
		end
	end

	// ==================================================
	// edge and level decode
	logic pwr_btn_fall;
	logic rst_btn_fall;
	logic power_good;
	logic pcie_wake;
	logic aux_wake;
	logic alert_level;
	logic alert_fall;
	logic lid_change;
	logic sleep_btn_fall;
	logic wake_any;
	// edges compare stage two with stage three, never the raw pin
	assign pwr_btn_fall   = prev[B_PWR_BTN] & ~sync[B_PWR_BTN];
	assign rst_btn_fall   = prev[B_RST_BTN] & ~sync[B_RST_BTN];
	assign power_good     = sync[B_PGOOD];
	assign pcie_wake      = ~sync[B_PCIE_WAKE];
	assign aux_wake       = ~sync[B_AUX_WAKE];
	assign alert_level    = ~sync[B_ALERT];
	assign alert_fall     = prev[B_ALERT] & ~sync[B_ALERT];
	assign lid_change     = prev[B_LID] ^ sync[B_LID];
	assign sleep_btn_fall = prev[B_SLEEP_BTN] & ~sync[B_SLEEP_BTN];
	// wake sources are levels, so a wake held across sleep entry
	// still resumes; the alert may wake as well as interrupt
	assign wake_any       = pcie_wake | aux_wake | alert_level;

	// ==================================================
	// power state machine
	pwr_mgr_pkg::pwr_state_t       state;
	pwr_mgr_pkg::pwr_state_t       next_state;
	logic [pwr_mgr_pkg::CNT_W-1:0] warn_cnt;
	logic                          warn_done;
	// warning stays out for the lead time before rails drop
	assign warn_done = (warn_cnt >= pwr_mgr_pkg::CNT_W'(WARN_LEN - 1));

	// next state; an off request wins over sleep in the same cycle
	always_comb begin
		next_state = state;
		unique case (state)
			pwr_mgr_pkg::ST_SOFT_OFF: begin
				if (pwr_btn_fall)
					next_state = pwr_mgr_pkg::ST_POWER_UP;
			end
			pwr_mgr_pkg::ST_POWER_UP: begin
				// wait for the supply before releasing the carrier
				if (power_good)
					next_state = pwr_mgr_pkg::ST_RUNNING;
			end
			pwr_mgr_pkg::ST_RUNNING: begin
				if (power_off_req_in)
					next_state = pwr_mgr_pkg::ST_SOFT_OFF;
				else if (sleep_req_in)
					next_state = pwr_mgr_pkg::ST_SUSP_WARN;
			end
			pwr_mgr_pkg::ST_SUSP_WARN: begin
				if (warn_done)
					next_state = pwr_mgr_pkg::ST_SLEEP_RAM;
			end
			pwr_mgr_pkg::ST_SLEEP_RAM: begin
				// a power button press resumes as well
				if (wake_any || pwr_btn_fall)
					next_state = pwr_mgr_pkg::ST_POWER_UP;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			state <= pwr_mgr_pkg::ST_SOFT_OFF;
		end else begin
			state <= next_state;
		end
	end

	// lead counter, idle at zero so each warning starts afresh
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			warn_cnt <= '0;
		end else if (state != pwr_mgr_pkg::ST_SUSP_WARN) begin
			warn_cnt <= '0;
		end else if (!warn_done) begin
			warn_cnt <= warn_cnt + 1'b1;
		end
	end

	// ==================================================
	// state decode
	// shared by the pin outputs so each test is written once
	logic in_soft_off;
	logic in_running;
	logic in_warn;
	logic in_sleep;
	logic powered;
	assign in_soft_off = (state == pwr_mgr_pkg::ST_SOFT_OFF);
	assign in_running  = (state == pwr_mgr_pkg::ST_RUNNING);
	assign in_warn     = (state == pwr_mgr_pkg::ST_SUSP_WARN);
	assign in_sleep    = (state == pwr_mgr_pkg::ST_SLEEP_RAM);
	assign powered     = in_running | in_warn;

	// ==================================================
	// carrier reset generator
	logic                          rst_active;
	logic [pwr_mgr_pkg::CNT_W-1:0] rst_cnt;
	logic                          pg_prev;
	logic                          v12_prev;
	logic                          cause_button;
	logic                          cause_pg_fall;
	logic                          cause_12v;
	logic                          cause_host;
	logic                          rst_trigger;

	// history for turning supply fault levels into edges
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			pg_prev  <= 1'b0;
			v12_prev <= 1'b0;
		end else begin
			pg_prev  <= power_good;
			v12_prev <= main_12v_low_in;
		end
	end

	// button and supply causes are edges, so a held button or fault cannot hold reset forever
	assign cause_button  = rst_btn_fall;
	assign cause_pg_fall = pg_prev & ~power_good;
	assign cause_12v     = main_12v_low_in & ~v12_prev;
	assign cause_host    = watchdog_timeout_in | sw_reset_req_in;
	assign rst_trigger   = cause_button | cause_pg_fall | cause_12v | cause_host;

	// pulse counter; a new trigger restarts the full length
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			rst_active <= 1'b1;
			rst_cnt    <= '0;
		end else if (rst_trigger) begin
			rst_active <= 1'b1;
			rst_cnt    <= '0;
		end else if (rst_active) begin
			if (rst_cnt >= pwr_mgr_pkg::CNT_W'(RESET_LEN - 1))
				rst_active <= 1'b0;
			else
				rst_cnt <= rst_cnt + 1'b1;
		end
	end

	// ==================================================
	// registered outputs
	// held in reset outside running and suspend warning, and while the pulse runs
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			carrier_reset_out_n_out <= 1'b0;
		end else begin
			carrier_reset_out_n_out <= ~(rst_active | ~powered);
		end
	end

	// warning stays low through sleep so bus devices stay quiet
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			suspend_warning_n_out <= 1'b1;
		end else begin
			suspend_warning_n_out <= ~(in_warn | in_sleep);
		end
	end

	// also low in soft-off, since the main rails are down there too
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			sleep_ram_state_n_out <= 1'b0;
		end else begin
			sleep_ram_state_n_out <= ~(in_sleep | in_soft_off);
		end
	end

	// suspend-to-disk never entered, so held inactive
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			sleep_disk_state_n_out <= 1'b1;
		end else begin
			sleep_disk_state_n_out <= 1'b1;
		end
	end

	// soft-off indication
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			soft_off_state_n_out <= 1'b0;
		end else begin
			soft_off_state_n_out <= ~in_soft_off;
		end
	end

	// ==================================================
	// thermal and battery levels
	// trip input is already on this clock, so no synchroniser
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			cpu_thermal_trip_n_out <= 1'b1;
		end else begin
			cpu_thermal_trip_n_out <= ~cpu_shutdown_in;
		end
	end

	// over-temp alarm follows the synchronised pin level
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			thermal_alarm_out <= 1'b0;
		end else begin
			thermal_alarm_out <= ~sync[B_OVER_TEMP];
		end
	end

	// battery low follows the synchronised pin level
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			battery_low_out <= 1'b0;
		end else begin
			battery_low_out <= ~sync[B_BATT_LOW];
		end
	end

	// ==================================================
	// event pulses
	// alert as interrupt only while running; asleep it wakes
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			mgmt_alert_smi_out <= 1'b0;
		end else begin
			mgmt_alert_smi_out <= alert_fall & in_running;
		end
	end

	// lid reports both closing and opening
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			lid_event_out <= 1'b0;
		end else begin
			lid_event_out <= lid_change;
		end
	end

	// sleep button reports the press only, not the release
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			sleep_button_event_out <= 1'b0;
		end else begin
			sleep_button_event_out <= sleep_btn_fall;
		end
	end
endmodule : power_state_and_reset_manager

// File: src/pwr_mgr_pkg.sv
// Purpose: constants for the power-state and reset manager
// Assumes: 125 MHz standby clock
// Notes:   counts derive from times at the clock rate
// Notes on behaviour
// - power button falling edge leaves soft-off
// - reset button active low, edge triggered
// - generated reset has bounded length
// - drive active-low carrier reset output
// - reset on button, power-good, 12V, watchdog, software
// - power-good high means main power valid
// - warn suspend before entering sleep
// - suspend-to-RAM indication low while asleep
// - suspend-to-disk indication unsupported
// - assert soft-off indication in soft-off
// - pcie wake resumes from sleep
// - auxiliary wake resumes from sleep
// - over-temperature input raises thermal alarm
// - thermal-trip low on thermal shutdown
// - management alert raises interrupt or wakes
// - report lid switch events
// - report sleep button presses
package pwr_mgr_pkg;
	// ==================================================
	// timing
	localparam int unsigned CLK_MHZ         = 125;
	localparam int unsigned RESET_PULSE_US  = 100;  // generated reset length
	localparam int unsigned RESET_CYCLES    = RESET_PULSE_US * CLK_MHZ;
	localparam int unsigned SUSP_WARN_US    = 1;    // warning lead before sleep
	localparam int unsigned SUSP_WARN_CYCLES = SUSP_WARN_US * CLK_MHZ;
	localparam int unsigned CNT_W           = 24;
	// ==================================================
	// power states
	typedef enum logic [2:0] {
		ST_SOFT_OFF,
		ST_POWER_UP,
		ST_RUNNING,
		ST_SUSP_WARN,
		ST_SLEEP_RAM
	} pwr_state_t;
endpackage : pwr_mgr_pkg

// File: sim/pwr_mgr_assertions.sv
// Purpose: pin-level checks for the power manager
// Assumes: one clock, synchronous active-high reset
// Notes: pin causes allow for two sync stages
`timescale 1ns/1ps
module pwr_mgr_assertions (
	input wire logic clk_in, sys_rst_in, power_button_n_in, reset_button_n_in, power_off_req_in,
	input wire logic pcie_wake_n_in, aux_wake_n_in, cpu_shutdown_in, lid_n_in, lid_event_out,
	input wire logic carrier_reset_out_n_out, suspend_warning_n_out, sleep_ram_state_n_out,
	input wire logic sleep_disk_state_n_out, soft_off_state_n_out, cpu_thermal_trip_n_out
);
	// ==========
	// checks, all on the standby clock
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	a_disk_high: assert property (sleep_disk_state_n_out) else $error("disk state driven");
	a_trip_follow: assert property (cpu_shutdown_in |=> !cpu_thermal_trip_n_out) else $error("no trip");
	a_warn_first: assert property (
		$fell(sleep_ram_state_n_out) && soft_off_state_n_out |-> !$past(suspend_warning_n_out)) else $error("no warn");
	a_off_request: assert property (
		power_off_req_in && carrier_reset_out_n_out && suspend_warning_n_out |-> ##[1:3] !soft_off_state_n_out)
		else $error("off request lost");
	a_power_up: assert property (
		$fell(power_button_n_in) && !soft_off_state_n_out |-> ##[2:6] soft_off_state_n_out) else $error("no power-up");
	a_reset_button: assert property (
		$fell(reset_button_n_in) && carrier_reset_out_n_out |-> ##[1:6] !carrier_reset_out_n_out) else $error("no reset");
	a_wake_resume: assert property (
		($fell(pcie_wake_n_in) || $fell(aux_wake_n_in)) && !sleep_ram_state_n_out && soft_off_state_n_out
		|-> ##[2:6] sleep_ram_state_n_out) else $error("no wake");
	a_lid_event: assert property ($changed(lid_n_in) |-> ##[2:5] lid_event_out) else $error("lid lost");
	c_sleep: cover property ($fell(sleep_ram_state_n_out) && soft_off_state_n_out);
	c_wake: cover property ($rose(sleep_ram_state_n_out));
	c_off: cover property ($fell(soft_off_state_n_out));
endmodule : pwr_mgr_assertions
bind power_state_and_reset_manager pwr_mgr_assertions u_chk (.*);

// File: sim/carrier_model.sv
// Purpose: carrier buttons, sensors and main supply
// Assumes: pins pulled up when released
// Notes: press length scaled down from 16 ms
`timescale 1ns/1ps
module carrier_model #(
	parameter int HOLD   = 30, // press length, cycles
	parameter int PG_DLY = 10  // supply settle time, cycles
) (
	input  wire logic       clk_in,               // bench clock
	input  wire logic       sys_rst_in,           // bench reset
	input  wire logic [9:0] press_in,             // press pulse; bit 9 browns out supply
	input  wire logic       sleep_ram_state_n_in, // sleep state from manager
	output logic      [8:0] pin_n_out,            // button and sensor pins
	output logic            power_good_out        // main supply good
);
	// ==========
	// press timers and supply
	int   cnt [10];
	int   pg_cnt;
	logic supply_rails_on;
	assign supply_rails_on = ~sleep_ram_state_n_in;
	always_ff @(posedge clk_in) begin
		for (int i = 0; i < 10; i++) begin
			if (sys_rst_in) cnt[i] <= 0;
			else if (press_in[i]) cnt[i] <= HOLD;
			else if (cnt[i] > 0) cnt[i] <= cnt[i] - 1;
		end
		if (sys_rst_in || supply_rails_on) pg_cnt <= 0;
		else if (pg_cnt < PG_DLY) pg_cnt <= pg_cnt + 1;
	end
	// released pins return to the pull-up level
	always_comb begin
		for (int i = 0; i < 9; i++) pin_n_out[i] = (cnt[i] == 0);
		power_good_out = (pg_cnt == PG_DLY) && (cnt[9] == 0);
	end
endmodule : carrier_model

// File: sim/power_state_and_reset_manager_tb_top.sv
// Purpose: self-checking bench for the power manager
// Assumes: shortened reset and warning counts
// Notes: pin events are queued and matched by a monitor
`timescale 1ns/1ps
module power_state_and_reset_manager_tb_top;
	// ==========
	// bench signals
	localparam int RLEN = 8;
	localparam int HOLD = 30;
	localparam int EVP [3] = '{7, 8, 6};
	localparam int WKP [3] = '{2, 3, 6};
	logic       clk_in, sys_rst_in, cpu_shutdown_in, power_good, v;
	logic [4:0] req;
	logic [9:0] press;
	logic [8:0] pin_n;
	logic       carrier_reset_out_n_out, suspend_warning_n_out, sleep_ram_state_n_out, sleep_disk_state_n_out;
	logic       soft_off_state_n_out, cpu_thermal_trip_n_out, thermal_alarm_out, battery_low_out;
	logic       mgmt_alert_smi_out, lid_event_out, sleep_button_event_out;
	logic [2:0] exp_q [$];
	int         err_total, samples_checked, k;
	power_state_and_reset_manager #(.RESET_LEN(RLEN), .WARN_LEN(4)) DUT (.*, .power_button_n_in(pin_n[0]),
		.reset_button_n_in(pin_n[1]), .main_power_good_in(power_good), .main_12v_low_in(req[0]),
		.watchdog_timeout_in(req[1]), .sw_reset_req_in(req[2]), .sleep_req_in(req[3]), .power_off_req_in(req[4]),
		.pcie_wake_n_in(pin_n[2]), .aux_wake_n_in(pin_n[3]), .battery_low_n_in(pin_n[4]),
		.overtemp_in_n_in(pin_n[5]), .mgmt_bus_alert_n_in(pin_n[6]), .lid_n_in(pin_n[7]), .sleep_button_n_in(pin_n[8]));
	carrier_model #(.HOLD(HOLD), .PG_DLY(10)) u_carrier (.clk_in, .sys_rst_in, .press_in(press),
		.sleep_ram_state_n_in(sleep_ram_state_n_out), .pin_n_out(pin_n), .power_good_out(power_good));
	// ==========
	// helpers
	task automatic wt(input int n);
		repeat (n) @(posedge clk_in);
	endtask : wt
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		samples_checked++;
		if (seen !== want) begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check
	// one-cycle request, then an idle edge so drives never collide
	task automatic pulse(input int b, input logic pin);
		if (pin) press[b] <= 1'h1;
		else req[b] <= 1'h1;
		wt(1);
		press <= 10'h000;
		req <= 5'h00;
		wt(1);
	endtask : pulse
	task automatic conclude();
		if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : conclude
	// ==========
	// clock, watchdog, event monitor
	initial begin
		clk_in = 1'h0;
		forever #4 clk_in = ~clk_in;
	end
	initial begin
		#32000;
		err_total++;
		conclude();
	end
	always @(posedge clk_in) begin
		#1;
		if (!sys_rst_in && {mgmt_alert_smi_out, lid_event_out, sleep_button_event_out} !== 3'h0)
			check({mgmt_alert_smi_out, lid_event_out, sleep_button_event_out}, exp_q.size() ? exp_q.pop_front() : 3'h0);
	end
	// ==========
	// main sequence
	initial begin
		sys_rst_in = 1'h1;
		req = 5'h00;
		press = 10'h000;
		cpu_shutdown_in = 1'h0;
		k = $urandom(32'h367dd508);
		wt(5);
		sys_rst_in <= 1'h0;
		wt(1);
		#1;
		check(soft_off_state_n_out, 1'h0);
		check(sleep_disk_state_n_out, 1'h1);
		wt(1);
		pulse(0, 1'h1);
		wt(40);
		#1;
		check(carrier_reset_out_n_out, 1'h1);
		// every reset cause, button held past the pulse length
		for (k = 0; k < 5; k++) begin
			wt(1 + $urandom % 4);
			if (k < 2) pulse(k == 0 ? 1 : 9, 1'h1);
			else pulse(k - 2, 1'h0);
			wt(5);
			#1;
			check(carrier_reset_out_n_out, 1'h0);
			wt(RLEN + 6);
			#1;
			check(carrier_reset_out_n_out, 1'h1);
			wt(HOLD);
		end
		repeat (16) begin
			v = 1'($urandom);
			wt(1);
			cpu_shutdown_in <= v;
			wt(1);
			#1;
			check(cpu_thermal_trip_n_out, !v);
		end
		wt(1);
		cpu_shutdown_in <= 1'h0;
		pulse(4, 1'h1);
		pulse(5, 1'h1);
		wt(6);
		#1;
		check(battery_low_out, 1'h1);
		check(thermal_alarm_out, 1'h1);
		exp_q = '{3'h2, 3'h2, 3'h1, 3'h4};
		foreach (EVP[i]) begin
			wt(HOLD);
			pulse(EVP[i], 1'h1);
		end
		// sleep, then wake by each source
		foreach (WKP[i]) begin
			wt(2 * HOLD);
			pulse(3, 1'h0);
			wt(2);
			#1;
			check({suspend_warning_n_out, sleep_ram_state_n_out}, 2'h1);
			wt(8);
			#1;
			check(sleep_ram_state_n_out, 1'h0);
			wt(20);
			pulse(WKP[i], 1'h1);
			wt(HOLD + RLEN + 20);
			#1;
			check({sleep_ram_state_n_out, carrier_reset_out_n_out}, 2'h3);
		end
		wt(1);
		pulse(4, 1'h0);
		wt(1);
		#1;
		check(soft_off_state_n_out, 1'h0);
		check(8'(exp_q.size()), 8'h00);
		conclude();
	end
endmodule : power_state_and_reset_manager_tb_top
